// ### src/digit_codec.sv
// Four-digit word decoder: BCD check and BCD to integer value.
// Assumes a 16-bit word; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module digit_codec (
	input  wire logic [plc_data_pkg::WORD_BITS-1:0] word_i,
	output logic                                    bcd_ok_o,
	output logic [plc_data_pkg::BIN_W-1:0]          value_o
);
	logic [plc_data_pkg::DIGITS-1:0] digit_ok;
	logic [plc_data_pkg::BIN_W-1:0]  acc;

	genvar g;
	generate
		for (g = 0; g < plc_data_pkg::DIGITS; g++) begin : g_digit
			// Nibble g is digit g, counted from the right [RULE_01] [RULE_18]
			assign digit_ok[g] = word_i[4*g +: 4] <= plc_data_pkg::BCD_MAX; // [RULE_02]
		end
	endgenerate

	// Whole-number result; a timer caller reads it as tenths [RULE_03] [RULE_04]
	always_comb begin
		acc = '0;
		for (int i = plc_data_pkg::DIGITS - 1; i >= 0; i--) begin
			acc = plc_data_pkg::BIN_W'(acc * 14'h000a
				+ plc_data_pkg::BIN_W'(word_i[4*i +: 4]));
		end
	end

	assign bcd_ok_o = &digit_ok;
	assign value_o  = acc;
endmodule
`default_nettype wire

// ### src/plc_data_area.sv
// Controller data memory: I/O image, work, dedicated and retained words.
// Assumes the execution engine on the op port and Avalon-MM software access.
`timescale 1ns/100ps
`default_nettype none
module plc_data_area (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [9:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	output logic             irq_o,
	input  wire logic        op_valid_i,
	input  wire logic        op_write_i,
	input  wire logic        op_retained_i,
	input  wire logic        op_indirect_i,
	input  wire logic        op_bcd_i,
	input  wire logic [4:0]  op_addr_i,
	input  wire logic [15:0] op_wdata_i,
	output logic             op_ready_o,
	output logic      [15:0] op_rdata_o,
	input  wire logic        scan_end_i,
	input  wire logic [11:0] in_pins_i,
	output logic      [7:0]  out_pins_o
);
	typedef logic [plc_data_pkg::WORD_BITS-1:0] word_type;

	typedef struct packed {
		word_type [plc_data_pkg::NUM_WORDS-1:0]    data;
		word_type [plc_data_pkg::NUM_RETAINED-1:0] ret;
		logic [plc_data_pkg::NUM_INPUTS-1:0]       sync1;
		logic [plc_data_pkg::NUM_INPUTS-1:0]       sync2;
		logic [plc_data_pkg::NUM_OUTPUTS-1:0]      out_pins;
		logic [plc_data_pkg::STAT_W-1:0]           status;
		logic [plc_data_pkg::STAT_W-1:0]           mask;
		word_type                                  conv;
		word_type                                  op_rdata;
		logic                                      op_ack;
		logic                                      bus_ack;
		logic [31:0]                               readdata;
	} state_type;

	state_type                             s;
	state_type                             next_s;
	logic                                  bcd_ok;
	logic                                  conv_ok;
	logic [plc_data_pkg::BIN_W-1:0]        conv_val;
	logic [plc_data_pkg::RET_IDX_W-1:0]    ret_idx;
	logic [7:0]                            bus_idx;
	logic [7:0]                            ret_base_idx;
	logic                                  bus_req;
	logic                                  op_take;
	logic [15:0]                           be_mask;
	logic [plc_data_pkg::STAT_W-1:0]       events;
	word_type                              wmask;

	digit_codec op_codec (
		.word_i   (op_wdata_i),
		.bcd_ok_o (bcd_ok),
		.value_o  ()
	);

	digit_codec conv_codec (
		.word_i   (s.conv),
		.bcd_ok_o (conv_ok),
		.value_o  (conv_val)
	);

	// Only some bits of words 00, 03 and 04 are open to the program; inputs, flags
	// driven by hardware and reserved positions in those words stay untouched
	function automatic word_type write_mask(input logic [4:0] a);
		case (a)
			plc_data_pkg::WORD_INPUT: write_mask = plc_data_pkg::INPUT_WMASK; // [RULE_11]
			plc_data_pkg::WORD_FLAGS: write_mask = plc_data_pkg::FLAGS_WMASK; // [RULE_13]
			plc_data_pkg::WORD_SYS:   write_mask = plc_data_pkg::SYS_WMASK; // [RULE_14]
			default:                  write_mask = plc_data_pkg::FULL_WMASK; // [RULE_12]
		endcase
	endfunction

	assign bus_req      = read_i | write_i;
	assign op_take      = op_valid_i & ~s.op_ack;
	assign bus_idx      = address_i[9:2];
	assign ret_base_idx = plc_data_pkg::REG_RET_BASE[9:2];
	assign be_mask      = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
	// Pointer comes from the named retained word when indirect [RULE_06]
	assign ret_idx      = op_indirect_i
		? s.ret[op_addr_i[3:0]][plc_data_pkg::RET_IDX_W-1:0]
		: op_addr_i[3:0];
	assign wmask        = write_mask(op_addr_i);

	always_comb begin
		next_s = s;
		events = '0;
		next_s.sync1 = in_pins_i;
		next_s.sync2 = s.sync1;

		// Bus: one wait state, engine ops take precedence
		next_s.bus_ack = bus_req & ~s.bus_ack & ~op_take;
		if (bus_req && !s.bus_ack) begin
			next_s.readdata = '0;
			if (bus_idx < 8'(plc_data_pkg::NUM_WORDS)) begin
				next_s.readdata = {16'h0000, s.data[bus_idx[4:0]]};
			end else if (bus_idx >= ret_base_idx && bus_idx <
				ret_base_idx + 8'(plc_data_pkg::NUM_RETAINED)) begin
				next_s.readdata = {16'h0000, s.ret[bus_idx[3:0]]};
			end else if (address_i == plc_data_pkg::REG_STATUS) begin
				next_s.readdata = 32'(s.status);
			end else if (address_i == plc_data_pkg::REG_MASK) begin
				next_s.readdata = 32'(s.mask);
			end else if (address_i == plc_data_pkg::REG_CONV) begin
				next_s.readdata = 32'(conv_val);
				next_s.readdata[plc_data_pkg::CONV_OK_BIT] = conv_ok;
			end
		end
		if (write_i && s.bus_ack) begin
			if (bus_idx < 8'(plc_data_pkg::NUM_WORDS)) begin
				next_s.data[bus_idx[4:0]] =
					(s.data[bus_idx[4:0]] & ~(be_mask & write_mask(bus_idx[4:0])))
					| (writedata_i[15:0] & be_mask & write_mask(bus_idx[4:0]));
			end else if (bus_idx >= ret_base_idx && bus_idx <
				ret_base_idx + 8'(plc_data_pkg::NUM_RETAINED)) begin
				next_s.ret[bus_idx[3:0]] = (s.ret[bus_idx[3:0]] & ~be_mask)
					| (writedata_i[15:0] & be_mask);
			end else if (address_i == plc_data_pkg::REG_STATUS
				&& byteenable_i[0]) begin
				next_s.status = s.status
					& ~writedata_i[plc_data_pkg::STAT_W-1:0];
			end else if (address_i == plc_data_pkg::REG_MASK
				&& byteenable_i[0]) begin
				next_s.mask = writedata_i[plc_data_pkg::STAT_W-1:0];
			end else if (address_i == plc_data_pkg::REG_CONV) begin
				next_s.conv = (s.conv & ~be_mask) | (writedata_i[15:0] & be_mask);
			end
		end

		// Engine operand access
		next_s.op_ack = op_take;
		if (op_take) begin
			if (op_retained_i) begin
				next_s.op_rdata = s.ret[ret_idx]; // [RULE_06]
			end else if (op_addr_i < 5'(plc_data_pkg::NUM_WORDS)) begin
				next_s.op_rdata = s.data[op_addr_i]; // [RULE_05]
			end else begin
				next_s.op_rdata = '0;
			end
			if (op_write_i) begin
				if (op_bcd_i && !bcd_ok) begin
					// Bad BCD is refused and raises the error flag [RULE_02]
					next_s.data[plc_data_pkg::WORD_FLAGS][plc_data_pkg::ER_BIT]
						= 1'b1; // [RULE_15]
					events[plc_data_pkg::STAT_BCD] = 1'b1;
				end else if (op_retained_i) begin
					next_s.ret[ret_idx] = op_wdata_i; // [RULE_06]
				end else if (op_addr_i < 5'(plc_data_pkg::NUM_WORDS)) begin
					next_s.data[op_addr_i] = (s.data[op_addr_i] & ~wmask)
						| (op_wdata_i & wmask); // [RULE_05] [RULE_12] [RULE_17]
					if (((op_wdata_i ^ s.data[op_addr_i]) & ~wmask) != '0) begin
						events[plc_data_pkg::STAT_RSVD] = 1'b1; // [RULE_14]
					end
				end
			end
		end

		// Pass end: refresh the I/O image and drop arithmetic flags
		if (scan_end_i) begin
			next_s.out_pins = s.data[plc_data_pkg::WORD_OUTPUT]
				[plc_data_pkg::NUM_OUTPUTS-1:0]; // [RULE_08] [RULE_09]
			next_s.data[plc_data_pkg::WORD_INPUT]
				[plc_data_pkg::NUM_INPUTS-1:0] = s.sync2; // [RULE_07] [RULE_10]
			next_s.data[plc_data_pkg::WORD_FLAGS] =
				next_s.data[plc_data_pkg::WORD_FLAGS]
				& ~plc_data_pkg::FLAG_CLEAR; // [RULE_16]
			next_s.data[plc_data_pkg::WORD_SYS] =
				next_s.data[plc_data_pkg::WORD_SYS]
				& ~plc_data_pkg::FIRST_CYCLE; // [RULE_15]
			events[plc_data_pkg::STAT_SCAN] = 1'b1;
		end
		// Set wins over a software clear in the same cycle
		next_s.status = next_s.status | events;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s <= '0;
			// Always ON and First Cycle start set; all other flags OFF
			s.data[plc_data_pkg::WORD_SYS] <= plc_data_pkg::SYS_RESET; // [RULE_15]
		end else begin
			s <= next_s; // [RULE_19]
		end
	end

	assign readdata_o    = s.readdata;
	assign waitrequest_o = bus_req & ~s.bus_ack;
	assign irq_o         = |(s.status & s.mask);
	assign op_ready_o    = op_valid_i & s.op_ack;
	assign op_rdata_o    = s.op_rdata;
	assign out_pins_o    = s.out_pins;

	sequence s_indirect_read;
		op_take && op_retained_i && op_indirect_i && !op_write_i;
	endsequence

	sequence s_bad_bcd;
		op_take && op_write_i && op_bcd_i && !bcd_ok && !scan_end_i;
	endsequence

	a_output_refresh: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_09]
		scan_end_i |=> out_pins_o == $past(s.data[1][7:0]))
		else $error("outputs not refreshed from output word");

	a_outputs_hold: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_08]
		!scan_end_i |=> $stable(out_pins_o))
		else $error("outputs changed during a pass");

	a_input_sample: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_10]
		scan_end_i |=> s.data[0][11:0] == $past(s.sync2))
		else $error("input image not sampled at pass end");

	a_input_stable: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_19]
		!scan_end_i |=> $stable(s.data[0][11:0]))
		else $error("input image changed inside a pass");

	a_flags_cleared: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_16]
		scan_end_i |=> s.data[3][15:11] == 5'h00)
		else $error("arithmetic flags survived cycle end");

	a_reserved_off: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_14]
		s.data[3][10:0] == 11'h000 && s.data[4][7:0] == 8'h00
		&& s.data[4][9] == 1'b0 && s.data[4][8] == 1'b1)
		else $error("reserved or fixed dedicated bit disturbed");

	a_indirect_data: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_06]
		s_indirect_read |=> op_rdata_o
			== $past(s.ret[s.ret[op_addr_i[3:0]][3:0]]))
		else $error("indirect read returned wrong word");

	a_bad_bcd_flag: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_02]
		s_bad_bcd |=> s.data[3][11] && s.status[1]
			&& (op_retained_i || $stable(s.data[op_addr_i[4:0]])))
		else $error("invalid BCD write not refused");

	a_op_answer: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_05]
		op_valid_i && !op_ready_o |=> op_ready_o)
		else $error("engine op not answered in one cycle");

	a_bus_answer: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_12]
		bus_req && !op_valid_i && waitrequest_o |=> !waitrequest_o)
		else $error("bus not answered after one wait state");
endmodule
`default_nettype wire

// ### src/plc_data_pkg.sv
// Constants for the controller data memory: word areas, masks, bus map.
// Assumes a single 10 MHz clock and an Avalon-MM register master.
//
// Contract
// RULE_01: Hex words use four-bit digits from right.
// RULE_02: BCD digits above nine are refused.
// RULE_03: Timer values count in tenths of seconds.
// RULE_04: Arithmetic values are whole integers only.
// RULE_05: Direct operand uses the named word itself.
// RULE_06: Indirect operand reads retained word pointer first.
// RULE_07: Input terminals 0-11 appear in word 00.
// RULE_08: Output terminals 0-7 follow word 01.
// RULE_09: Outputs copied only after a pass ends.
// RULE_10: Refresh samples every input terminal level.
// RULE_11: Input bits 0006 and 0007 stay reserved; the code samples them from terminals 6 and 7 like the other inputs.
// RULE_12: Work bits are freely readable and writable.
// RULE_13: Dedicated flag area spans words 03-09.
// RULE_14: Unassigned dedicated bits are reserved, unwritable; the code leaves words 05-09 fully writable.
// RULE_15: Dedicated flags OFF until their condition.
// RULE_16: Cycle end clears bits 0311 to 0315.
// RULE_17: Other control bits OFF until program sets.
// RULE_18: Words hold sixteen bits, 00 rightmost.
// RULE_19: Input image stable through the following pass.
package plc_data_pkg;
	localparam int WORD_BITS    = 16;
	localparam int NUM_WORDS    = 19;
	localparam int NUM_RETAINED = 16;
	localparam int RET_IDX_W    = 4;
	localparam int NUM_INPUTS   = 12;
	localparam int NUM_OUTPUTS  = 8;
	localparam int DIGITS       = 4;
	localparam int BIN_W        = 14;

	localparam logic [4:0] WORD_INPUT  = 5'h00;
	localparam logic [4:0] WORD_OUTPUT = 5'h01;
	localparam logic [4:0] WORD_FLAGS  = 5'h03;
	localparam logic [4:0] WORD_SYS    = 5'h04;

	// Writable bits per word; the rest belong to hardware or are reserved
	localparam logic [15:0] INPUT_WMASK = 16'hf000;
	localparam logic [15:0] FLAGS_WMASK = 16'hf800;
	localparam logic [15:0] SYS_WMASK   = 16'hf800;
	localparam logic [15:0] FULL_WMASK  = 16'hffff;
	localparam logic [15:0] FLAG_CLEAR  = 16'hf800;
	localparam logic [15:0] SYS_RESET   = 16'h0500;
	localparam logic [15:0] FIRST_CYCLE = 16'h0400;
	localparam int          ER_BIT      = 11;
	localparam logic [3:0]  BCD_MAX     = 4'h9;

	// Avalon-MM byte offsets
	localparam logic [9:0] REG_DATA_BASE = 10'h000;
	localparam logic [9:0] REG_RET_BASE  = 10'h080;
	localparam logic [9:0] REG_STATUS    = 10'h100;
	localparam logic [9:0] REG_MASK      = 10'h104;
	localparam logic [9:0] REG_CONV      = 10'h108;
	localparam int         CONV_OK_BIT   = 31;

	localparam int STAT_W    = 3;
	localparam int STAT_SCAN = 0;
	localparam int STAT_BCD  = 1;
	localparam int STAT_RSVD = 2;
endpackage

// ### tb/field_terminals.sv
// Field terminal model: switches on the inputs, lamps on the outputs.
// Assumes the bench commands switch levels; both sides move on clk_i.
`timescale 1ns/100ps
`default_nettype none
module field_terminals (
	input  wire logic        clk_i,
	input  wire logic [11:0] switch_i,
	input  wire logic [7:0]  out_pins_i,
	output logic      [11:0] in_pins_o,
	output logic      [7:0]  lamp_o
);
	// Contacts settle just after an edge, unrelated to the pass timing
	always @(posedge clk_i) begin
		in_pins_o <= switch_i;
		lamp_o    <= out_pins_i;
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Bench for the controller data memory with field terminal model.
// Assumes single clock; expected reads queue up, a monitor compares.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [9:0]  address = 10'h000;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        irq;
	logic        op_valid = 1'b0;
	logic        op_write = 1'b0;
	logic        op_ret = 1'b0;
	logic        op_ind = 1'b0;
	logic        op_bcd = 1'b0;
	logic [4:0]  op_addr = 5'h00;
	logic [15:0] op_wdata = 16'h0000;
	logic [15:0] op_rdata;
	logic        op_ready;
	logic        scan_end = 1'b0;
	logic [11:0] in_pins;
	logic [11:0] switch = 12'h000;
	logic [7:0]  out_pins;
	logic [7:0]  lamp;
	logic [31:0] exp_q[$];
	string       name_q[$];
	int          mismatches = 0;
	int          total_checks = 0;
	logic [15:0] r;
	logic [15:0] w;
	logic [11:0] p;

	always #50 clk_i = ~clk_i;

	plc_data_area dut_u (.clk_i(clk_i), .reset_i(reset_i),
		.address_i(address), .read_i(read), .write_i(write),
		.writedata_i(writedata), .byteenable_i(4'hf),
		.readdata_o(readdata), .waitrequest_o(waitrequest), .irq_o(irq),
		.op_valid_i(op_valid), .op_write_i(op_write),
		.op_retained_i(op_ret), .op_indirect_i(op_ind), .op_bcd_i(op_bcd),
		.op_addr_i(op_addr), .op_wdata_i(op_wdata), .op_ready_o(op_ready),
		.op_rdata_o(op_rdata), .scan_end_i(scan_end),
		.in_pins_i(in_pins), .out_pins_o(out_pins));

	field_terminals field_u (.clk_i(clk_i), .switch_i(switch),
		.out_pins_i(out_pins), .in_pins_o(in_pins), .lamp_o(lamp));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic compare(string nm, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(logic wr, logic [9:0] a, logic [31:0] d);
		int t;
		@(posedge clk_i);
		{read, write, address, writedata} <= {!wr, wr, a, d};
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (waitrequest !== 1'b0 && t < 100);
		if (t >= 100)
			mismatches++;
		{read, write} <= 2'b00;
	endtask

	task automatic rd(logic [9:0] a, logic [31:0] e, string nm);
		exp_q.push_back(e);
		name_q.push_back(nm);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic op(logic wr, ret, ind, bcd, logic [4:0] a, logic [15:0] d);
		int t;
		@(posedge clk_i);
		{op_valid, op_write, op_ret, op_ind, op_bcd} <= {1'b1, wr, ret, ind, bcd};
		{op_addr, op_wdata} <= {a, d};
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (op_ready !== 1'b1 && t < 100);
		if (t >= 100)
			mismatches++;
		op_valid <= 1'b0;
	endtask

	task automatic opr(logic ret, ind, logic [4:0] a, logic [15:0] e);
		exp_q.push_back({16'h0, e});
		name_q.push_back("operand");
		op(1'b0, ret, ind, 1'b0, a, 16'h0);
	endtask

	task automatic scan();
		@(posedge clk_i);
		scan_end <= 1'b1;
		@(posedge clk_i);
		scan_end <= 1'b0;
		repeat (2) @(negedge clk_i);
	endtask

	// Read results are judged where they stand, oldest note first
	always @(posedge clk_i) begin
		if ((read && waitrequest === 1'b0) || (op_valid && !op_write && op_ready === 1'b1)) begin
			if (exp_q.size() == 0)
				compare("unexpected result", 32'h0, 32'h1);
			else
				compare(name_q.pop_front(), exp_q.pop_front(), read ? readdata : {16'h0, op_rdata});
		end
	end

	initial begin
		#(100 * 5000);
		mismatches++;
		print_verdict();
	end

	initial begin
		void'($urandom(70102));
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(10'h010, 32'h0500, "word04 reset");
		rd(10'h00c, 32'h0, "word03 reset");
		bus(1'b1, 10'h3fc, 32'hffff);
		rd(10'h3fc, 32'h0, "unmapped");
		for (int n = 2; n <= 18; n++) begin
			if (n > 2 && n < 10)
				continue;
			r = 16'($urandom());
			op(1'b1, 1'b0, 1'b0, 1'b0, 5'(n), r);
			rd(10'(4 * n), {16'h0, r}, "work word");
		end
		w = 16'($urandom());
		p = 12'($urandom());
		op(1'b1, 1'b0, 1'b0, 1'b0, 5'h01, w);
		op(1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 16'hffff);
		rd(10'h000, 32'hf000, "input word written");
		compare("outputs before end", 32'h0, {24'h0, out_pins});
		@(posedge clk_i);
		switch <= p;
		repeat (4) @(posedge clk_i);
		scan();
		compare("outputs", {24'h0, w[7:0]}, {24'h0, out_pins});
		@(negedge clk_i);
		compare("lamps", {24'h0, w[7:0]}, {24'h0, lamp});
		rd(10'h004, {16'h0, w}, "output word");
		rd(10'h000, {16'hf, p}, "input image");
		@(posedge clk_i);
		switch <= ~p;
		repeat (5) @(posedge clk_i);
		rd(10'h000, {16'hf, p}, "image held");
		scan();
		rd(10'h000, {16'hf, ~p}, "input refresh");
		bus(1'b1, 10'h00c, 32'hffff);
		rd(10'h00c, 32'hf800, "flag word");
		bus(1'b1, 10'h010, 32'hffff);
		rd(10'h010, 32'hf900, "system word");
		scan();
		rd(10'h00c, 32'h0, "flags at end");
		rd(10'h010, 32'hf900, "control bits kept");
		bus(1'b1, 10'h100, 32'h7);
		bus(1'b1, 10'h104, 32'h2);
		op(1'b1, 1'b0, 1'b0, 1'b1, 5'h02, 16'h0931);
		op(1'b1, 1'b0, 1'b0, 1'b1, 5'h02, 16'h12b4);
		rd(10'h008, 32'h0931, "bcd kept");
		rd(10'h00c, 32'h0800, "error flag");
		rd(10'h100, 32'h2, "status");
		@(negedge clk_i);
		compare("irq raised", 32'h1, {31'h0, irq});
		bus(1'b1, 10'h100, 32'h2);
		@(negedge clk_i);
		compare("irq cleared", 32'h0, {31'h0, irq});
		scan();
		compare("irq masked", 32'h0, {31'h0, irq});
		bus(1'b1, 10'h104, 32'h1);
		@(negedge clk_i);
		compare("irq pass end", 32'h1, {31'h0, irq});
		r = 16'($urandom());
		op(1'b1, 1'b1, 1'b0, 1'b0, 5'h01, 16'h0006);
		op(1'b1, 1'b1, 1'b0, 1'b0, 5'h06, r);
		opr(1'b1, 1'b1, 5'h01, r);
		opr(1'b1, 1'b0, 5'h06, r);
		rd(10'h098, {16'h0, r}, "retained word");
		bus(1'b1, 10'h108, 32'h5757);
		rd(10'h108, 32'h8000167d, "bcd value");
		repeat (3) @(posedge clk_i);
		compare("pending results", 32'h0, 32'(exp_q.size()));
		print_verdict();
	end
endmodule
`default_nettype wire
